// ---- design/ppm_top.sv ----
// Port pin mode configuration registers with APB slave
`timescale 1ns/1ps
module ppm_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ppm_pkg::BUS_W-1:0] paddr,
  input wire logic [ppm_pkg::BUS_W-1:0] pwdata,
  input wire logic [ppm_pkg::STRB_W-1:0] pstrb,
  output logic [ppm_pkg::BUS_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [ppm_pkg::PORT_MODE_W-1:0] port1_pin_mode,
  output logic [ppm_pkg::PORT_MODE_W-1:0] port3_pin_mode,
  output logic [ppm_pkg::PORT_PINS-1:0] port1_analog_en,
  output logic [ppm_pkg::PORT_PINS-1:0] port3_analog_en
);
  import ppm_pkg::*;

  // ****************************************
  // Mode registers
  // ****************************************
  logic [REG_W-1:0] port1_low_pin_modes;
  logic [REG_W-1:0] next_port1_low_pin_modes;
  logic [REG_W-1:0] port1_high_pin_modes;
  logic [REG_W-1:0] next_port1_high_pin_modes;
  logic [REG_W-1:0] port3_low_pin_modes;
  logic [REG_W-1:0] next_port3_low_pin_modes;
  logic [REG_W-1:0] port3_high_pin_modes;
  logic [REG_W-1:0] next_port3_high_pin_modes;

  // ****************************************
  // Bus decode signals
  // ****************************************
  logic access;
  logic commit;
  logic wr_commit;
  logic addr_aligned;
  logic addr_upper_zero;
  logic hit;
  logic [ADDR_W-1:0] sel_idx;
  logic wr_port1_low;
  logic wr_port1_high;
  logic wr_port3_low;
  logic wr_port3_high;

  // ****************************************
  // Bus response signals
  // ****************************************
  logic [REG_W-1:0] rd_reg;
  logic [BUS_W-1:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  // ****************************************
  // Pin-side next values
  // ****************************************
  logic [PORT_MODE_W-1:0] next_port1_pin_mode;
  logic [PORT_MODE_W-1:0] next_port3_pin_mode;
  logic [PORT_PINS-1:0] next_port1_analog_en;
  logic [PORT_PINS-1:0] next_port3_analog_en;

  // ****************************************
  // Address decode, write lands with pready
  // ****************************************
  always_comb begin
    access = psel && penable && !pready;
    commit = psel && penable && pready;
    wr_commit = commit && pwrite && pstrb[0];
    sel_idx = paddr[WORD_LSB +: ADDR_W];
    addr_aligned = (paddr[WORD_LSB-1:0] == '0);
    addr_upper_zero = (paddr[BUS_W-1:WORD_LSB+ADDR_W] == '0);
    hit = addr_aligned && addr_upper_zero
      && (sel_idx >= PORT1_LOW_IDX) && (sel_idx <= PORT3_HIGH_IDX);
    wr_port1_low = wr_commit && hit && (sel_idx == PORT1_LOW_IDX);
    wr_port1_high = wr_commit && hit && (sel_idx == PORT1_HIGH_IDX);
    wr_port3_low = wr_commit && hit && (sel_idx == PORT3_LOW_IDX);
    wr_port3_high = wr_commit && hit && (sel_idx == PORT3_HIGH_IDX);
  end

  // ****************************************
  // Port 1 low mode register
  // ****************************************
  always_comb begin
    next_port1_low_pin_modes = port1_low_pin_modes;
    if (wr_port1_low) begin
      next_port1_low_pin_modes = pwdata[REG_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port1_low_pin_modes <= PORT1_LOW_RST;
    end else begin
      port1_low_pin_modes <= next_port1_low_pin_modes;
    end
  end

  // ****************************************
  // Port 1 high mode register
  // ****************************************
  always_comb begin
    next_port1_high_pin_modes = port1_high_pin_modes;
    if (wr_port1_high) begin
      next_port1_high_pin_modes = pwdata[REG_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port1_high_pin_modes <= PORT1_HIGH_RST;
    end else begin
      port1_high_pin_modes <= next_port1_high_pin_modes;
    end
  end

  // ****************************************
  // Port 3 low mode register
  // ****************************************
  always_comb begin
    next_port3_low_pin_modes = port3_low_pin_modes;
    if (wr_port3_low) begin
      next_port3_low_pin_modes = pwdata[REG_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port3_low_pin_modes <= PORT3_LOW_RST;
    end else begin
      port3_low_pin_modes <= next_port3_low_pin_modes;
    end
  end

  // ****************************************
  // Port 3 high mode register
  // ****************************************
  always_comb begin
    next_port3_high_pin_modes = port3_high_pin_modes;
    if (wr_port3_high) begin
      next_port3_high_pin_modes = pwdata[REG_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port3_high_pin_modes <= PORT3_HIGH_RST;
    end else begin
      port3_high_pin_modes <= next_port3_high_pin_modes;
    end
  end

  // ****************************************
  // Bus response
  // ****************************************
  always_comb begin
    next_pready = access;
    next_pslverr = access && !hit;
    rd_reg = '0;
    if (access && !pwrite && hit) begin
      unique case (sel_idx)
        PORT1_LOW_IDX: rd_reg = port1_low_pin_modes;
        PORT1_HIGH_IDX: rd_reg = port1_high_pin_modes;
        PORT3_LOW_IDX: rd_reg = port3_low_pin_modes;
        PORT3_HIGH_IDX: rd_reg = port3_high_pin_modes;
        default: rd_reg = '0;
      endcase
    end
    next_prdata = '0;
    next_prdata[REG_W-1:0] = rd_reg;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ****************************************
  // Analog converter input decode
  // ****************************************
  for (genvar i = 0; i < PORT_PINS; i++) begin : g_pin
    assign next_port1_analog_en[i] = PORT1_ANALOG_CAP[i]
      && (next_port1_pin_mode[FIELD_W*i +: FIELD_W] == MODE3);
    assign next_port3_analog_en[i] = PORT3_ANALOG_CAP[i]
      && (next_port3_pin_mode[FIELD_W*i +: FIELD_W] == MODE3);
  end

  // ****************************************
  // Port 1 pin-side outputs
  // ****************************************
  always_comb begin
    next_port1_pin_mode = {next_port1_high_pin_modes,
      next_port1_low_pin_modes};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port1_pin_mode <= {PORT1_HIGH_RST, PORT1_LOW_RST};
      port1_analog_en <= '0;
    end else begin
      port1_pin_mode <= next_port1_pin_mode;
      port1_analog_en <= next_port1_analog_en;
    end
  end

  // ****************************************
  // Port 3 pin-side outputs
  // ****************************************
  always_comb begin
    next_port3_pin_mode = {next_port3_high_pin_modes,
      next_port3_low_pin_modes};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port3_pin_mode <= {PORT3_HIGH_RST, PORT3_LOW_RST};
      port3_analog_en <= '0;
    end else begin
      port3_pin_mode <= next_port3_pin_mode;
      port3_analog_en <= next_port3_analog_en;
    end
  end
endmodule // ppm_top

// ---- design/ppm_pkg.sv ----
// Package for the port pin mode configuration block
package ppm_pkg;
  // ****************************************
  // Register indices, byte address is four times the index
  // ****************************************
  localparam logic [7:0] PORT1_LOW_IDX = 8'ha2;
  localparam logic [7:0] PORT1_HIGH_IDX = 8'ha3;
  localparam logic [7:0] PORT3_LOW_IDX = 8'ha4;
  localparam logic [7:0] PORT3_HIGH_IDX = 8'ha5;
  // ****************************************
  // Bus layout
  // ****************************************
  localparam int BUS_W = 32;
  localparam int STRB_W = 4;
  localparam int WORD_LSB = 2;
  // ****************************************
  // Field layout and codes
  // ****************************************
  localparam int FIELD_W = 2;
  localparam int PINS_PER_REG = 4;
  localparam int REG_W = 8;
  localparam int ADDR_W = 8;
  localparam int PORT_PINS = 2 * PINS_PER_REG;
  localparam int PORT_MODE_W = FIELD_W * PORT_PINS;
  localparam logic [1:0] MODE0 = 2'h0;
  localparam logic [1:0] MODE1 = 2'h1;
  localparam logic [1:0] MODE2 = 2'h2;
  localparam logic [1:0] MODE3 = 2'h3;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] PORT1_LOW_RST = 8'h55;
  localparam logic [7:0] PORT1_HIGH_RST = 8'h55;
  localparam logic [7:0] PORT3_LOW_RST = 8'h55;
  localparam logic [7:0] PORT3_HIGH_RST = 8'h15;
  // Pins of each port that can become analog converter inputs
  localparam logic [7:0] PORT1_ANALOG_CAP = 8'h3f;
  localparam logic [7:0] PORT3_ANALOG_CAP = 8'h0f;
endpackage

// ---- test/ppm_top_assertions.sv ----
// Checker for the port pin mode configuration block
`timescale 1ns/1ps
module ppm_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] port1_pin_mode,
  input wire logic [15:0] port3_pin_mode,
  input wire logic [7:0] port1_analog_en,
  input wire logic [7:0] port3_analog_en
);
  function automatic logic [3:0] an(input logic [7:0] m);
    return {&m[7:6], &m[5:4], &m[3:2], &m[1:0]};
  endfunction
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_p1l; port1_analog_en[3:0] == an(port1_pin_mode[7:0]); endproperty
  a_p1l: assert property (p_p1l) else $error("p1 low analog");
  property p_p1h; port1_analog_en[7:4] == (an(port1_pin_mode[15:8]) & 4'h3);
  endproperty
  a_p1h: assert property (p_p1h) else $error("p1 high analog");
  property p_p3l; port3_analog_en[3:0] == an(port3_pin_mode[7:0]); endproperty
  a_p3l: assert property (p_p3l) else $error("p3 low analog");
  property p_p3h; port3_analog_en[7:4] == 4'h0; endproperty
  a_p3h: assert property (p_p3h) else $error("p3 high analog");
  property p_rst; $rose(rst_n) |-> port1_pin_mode == 16'h5555 &&
    port3_pin_mode == 16'h1555; endproperty
  a_rst: assert property (p_rst) else $error("reset modes");
  property p_rd; pready && !pwrite && paddr == 32'h290 |->
    prdata == {24'h0, port3_pin_mode[7:0]}; endproperty
  a_rd: assert property (p_rd) else $error("read data");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready pulse");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("error response");
endmodule // ppm_chk
bind ppm_top ppm_chk u_chk (.*);

// ---- test/test_port_pin_mode_config.sv ----
// Testbench for the port pin mode configuration block
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED %0t value mismatch", $time); end end
module test_port_pin_mode_config;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rdat;
  logic [3:0] pstrb = 0;
  logic [15:0] port1_pin_mode, port3_pin_mode;
  logic [7:0] port1_analog_en, port3_analog_en;
  logic pslverr, rerr;
  logic [7:0] rv [4] = '{8'h55, 8'h55, 8'h55, 8'h15};
  logic [7:0] pat [2] = '{8'he4, 8'h1b};
  logic [7:0] e1 [2] = '{8'h08, 8'h11};
  logic [7:0] e3 [2] = '{8'h08, 8'h01};
  int n_fail = 0, compares = 0;
  ppm_top u_dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .port1_pin_mode, .port3_pin_mode,
    .port1_analog_en, .port3_analog_en);
  task automatic xfer(input logic w, input logic [31:0] a,
    input logic [7:0] d, input logic [3:0] s);
    @(posedge clk);
    {psel, penable, pwrite, pstrb} <= {2'b10, w, s};
    {paddr, pwdata} <= {a, 24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic report_and_stop;
    if (n_fail == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial forever #20 clk = ~clk;
  initial begin
    repeat (1000) @(posedge clk);
    n_fail++;
    report_and_stop;
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      xfer(0, 32'h288 + 4 * i, 0, 4'hf);
      `CHK(rdat, rv[i])
      `CHK(rerr, 1'b0)
    end
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 4; i++) xfer(1, 32'h288 + 4 * i, pat[p], 4'h1);
      for (int i = 0; i < 4; i++) begin
        xfer(0, 32'h288 + 4 * i, 0, 4'hf);
        `CHK(rdat, pat[p])
      end
      `CHK(port1_analog_en, e1[p])
      `CHK(port3_analog_en, e3[p])
      `CHK({port1_pin_mode, port3_pin_mode}, {4{pat[p]}})
    end
    xfer(1, 32'h294, 8'hff, 4'h0);
    xfer(0, 32'h294, 0, 4'hf);
    `CHK(rdat, 8'h1b)
    xfer(0, 32'h298, 0, 4'hf);
    `CHK(rerr, 1'b1)
    xfer(1, 32'h289, 8'hff, 4'hf);
    `CHK(rerr, 1'b1)
    `CHK(port1_pin_mode, 16'h1b1b)
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    `CHK({port1_pin_mode, port3_pin_mode}, 32'h5555_1555)
    `CHK({port1_analog_en, port3_analog_en}, 16'h0000)
    xfer(0, 32'h294, 0, 4'hf);
    `CHK(rdat, 8'h15)
    report_and_stop;
  end
endmodule // test_port_pin_mode_config
